/* File: src/lbc_defines.vh */
// constants for the local bus cycle control block
`ifndef LBC_DEFINES_VH
`define LBC_DEFINES_VH
// status codes, high bit first
`define LBC_ST_INTA 3'h0
`define LBC_ST_IORD 3'h1
`define LBC_ST_IOWR 3'h2
`define LBC_ST_HALT 3'h3
`define LBC_ST_FETCH 3'h4
`define LBC_ST_MEMRD 3'h5
`define LBC_ST_MEMWR 3'h6
`define LBC_ST_PASSIVE 3'h7
// direct i/o port range upper bound
`define LBC_IO_DIRECT_MAX 16'h00ff
// reset value of strobes (inactive high)
`define LBC_STROBE_IDLE 1'h1
`endif

/* File: src/lbc_status_decode.v */
// status code and strobe kind for a requested cycle type
`timescale 1ns/1ns
`default_nettype none
`include "lbc_defines.vh"
module lbc_status_decode (
  // request
  input wire [2:0] kind,
  input wire io_space,
  // decoded
  output reg [2:0] code,
  output reg is_read,
  output reg is_write
);
  // kind: 0 inta, 1 read, 2 write, 3 halt, 4 fetch
  always @* begin
    is_read = 1'b0;
    is_write = 1'b0;
    case (kind)
      3'h0: code = `LBC_ST_INTA;
      3'h1: begin
        code = io_space ? `LBC_ST_IORD : `LBC_ST_MEMRD;
        is_read = 1'b1;
      end
      3'h2: begin
        code = io_space ? `LBC_ST_IOWR : `LBC_ST_MEMWR;
        is_write = 1'b1;
      end
      3'h3: code = `LBC_ST_HALT;
      3'h4: begin
        code = `LBC_ST_FETCH;
        is_read = 1'b1;
      end
      default: code = `LBC_ST_PASSIVE;
    endcase
  end
endmodule // lbc_status_decode
`default_nettype wire

/* File: src/lbc_cycle_ctrl.v */
// bus cycle controller of a multiplexed local bus
`timescale 1ns/1ns
`default_nettype none
`include "lbc_defines.vh"
module lbc_cycle_ctrl (
  // clock and reset
  input wire CLK_SYS,
  input wire RESET,
  // variant strap: 1 = 8-bit external bus
  input wire BYTE_BUS,
  // cycle request from the execution side
  input wire REQ_VALID,
  input wire [2:0] REQ_KIND,
  input wire REQ_IO,
  input wire REQ_DIRECT,
  input wire [7:0] REQ_PORT8,
  input wire [19:0] REQ_ADDR,
  input wire REQ_WORD,
  input wire REQ_PERIPH,
  input wire [15:0] REQ_WDATA,
  output reg REQ_READY,
  // completion
  output reg DONE,
  output reg [15:0] RDATA,
  // internal peripheral word port
  output reg PERIPH_STB,
  output reg PERIPH_WR,
  output reg [15:0] PERIPH_ADDR,
  output reg [15:0] PERIPH_WDATA,
  input wire [15:0] PERIPH_RDATA,
  // external bus
  input wire READY,
  input wire [15:0] AD_IN,
  output reg [15:0] AD_OUT,
  output reg AD_OE,
  output reg [19:0] ADDR,
  output reg UPPER_LANE_ENABLE_N,
  output reg RD_N,
  output reg WR_N,
  output reg CYCLE_STATUS_HI,
  output reg CYCLE_STATUS_MID,
  output reg CYCLE_STATUS_LO,
  output reg CS_MEM_N,
  output reg CS_IO_N
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_PRE = 3'h1;
  localparam [2:0] ST_T1 = 3'h2;
  localparam [2:0] ST_T2 = 3'h3;
  localparam [2:0] ST_T3 = 3'h4;
  localparam [2:0] ST_T4 = 3'h5;
  localparam [2:0] ST_PER = 3'h6;

  // lane placement: returns {upper_enable_n, a0_forced}
  function [1:0] lane_sel;
    input a0;
    input word;
    input byte_bus;
    begin
      if (byte_bus)
        lane_sel = 2'h2;
      else
        lane_sel = {~(a0 | word), a0};
    end
  endfunction

  reg [2:0] state;
  reg [2:0] kind;
  reg io;
  reg [19:0] addr;
  reg [15:0] wdata;
  reg second;
  reg split;
  reg periph;
  reg [2:0] code;
  wire [2:0] dec_code;
  wire dec_rd;
  wire dec_wr;
  wire [19:0] req_eff;
  wire [1:0] lanes;

  lbc_status_decode i_lbc_status_decode (
    .kind(kind),
    .io_space(io),
    .code(dec_code),
    .is_read(dec_rd),
    .is_write(dec_wr)
  );

  // i/o: direct form zero-extends the 8-bit port, else 16-bit pointer
  assign req_eff = !REQ_IO ? REQ_ADDR :
    (REQ_DIRECT ? {12'h000, REQ_PORT8} :
    {4'h0, REQ_ADDR[15:0]});
  assign lanes = lane_sel(addr[0], split ? 1'b0 : 1'b1, BYTE_BUS);

  always @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      state <= ST_IDLE;
      kind <= 3'h0;
      io <= 1'b0;
      addr <= 20'h00000;
      wdata <= 16'h0000;
      second <= 1'b0;
      split <= 1'b0;
      periph <= 1'b0;
      code <= `LBC_ST_PASSIVE;
      REQ_READY <= 1'b1;
      DONE <= 1'b0;
      RDATA <= 16'h0000;
      PERIPH_STB <= 1'b0;
      PERIPH_WR <= 1'b0;
      PERIPH_ADDR <= 16'h0000;
      PERIPH_WDATA <= 16'h0000;
      AD_OUT <= 16'h0000;
      AD_OE <= 1'b0;
      ADDR <= 20'h00000;
      UPPER_LANE_ENABLE_N <= 1'b1;
      RD_N <= `LBC_STROBE_IDLE;
      WR_N <= `LBC_STROBE_IDLE;
      {CYCLE_STATUS_HI, CYCLE_STATUS_MID, CYCLE_STATUS_LO} <=
        `LBC_ST_PASSIVE;
      CS_MEM_N <= 1'b1;
      CS_IO_N <= 1'b1;
    end else begin
      DONE <= 1'b0;
      PERIPH_STB <= 1'b0;
      case (state)
        ST_IDLE: begin
          // idle keeps passive status and strobes high
          {CYCLE_STATUS_HI, CYCLE_STATUS_MID, CYCLE_STATUS_LO} <=
            `LBC_ST_PASSIVE;
          RD_N <= 1'b1;
          WR_N <= 1'b1;
          AD_OE <= 1'b0;
          if (REQ_VALID && REQ_READY) begin
            REQ_READY <= 1'b0;
            kind <= REQ_KIND;
            io <= REQ_IO;
            addr <= req_eff;
            wdata <= REQ_WDATA;
            second <= 1'b0;
            periph <= REQ_PERIPH;
            // odd word on 16-bit bus also needs two cycles
            split <= REQ_WORD && (BYTE_BUS || req_eff[0]);
            if (REQ_PERIPH) begin
              // peripherals always move a whole word inside
              PERIPH_STB <= 1'b1;
              PERIPH_WR <= (REQ_KIND == 3'h2);
              PERIPH_ADDR <= {req_eff[15:1], 1'b0};
              PERIPH_WDATA <= REQ_WDATA;
              state <= ST_PER;
            end else begin
              state <= ST_PRE;
            end
          end
        end
        ST_PER: begin
          RDATA <= PERIPH_RDATA;
          if (kind == 3'h1 || kind == 3'h2) begin
            // read or write still shows one unsplit bus cycle outside
            split <= 1'b0;
            state <= ST_PRE;
          end else begin
            DONE <= 1'b1;
            REQ_READY <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_PRE: begin
          // status goes active in the state before address phase
          {CYCLE_STATUS_HI, CYCLE_STATUS_MID, CYCLE_STATUS_LO} <=
            dec_code;
          code <= dec_code;
          state <= ST_T1;
        end
        ST_T1: begin
          ADDR <= addr;
          AD_OUT <= addr[15:0];
          AD_OE <= (kind != 3'h3);
          UPPER_LANE_ENABLE_N <= lanes[1];
          // chip select follows its own space only
          CS_MEM_N <= !((dec_rd || dec_wr) && !io);
          CS_IO_N <= !((dec_rd || dec_wr) && io);
          state <= ST_T2;
        end
        ST_T2: begin
          // address released in the same cycle the read strobe falls
          AD_OE <= dec_wr;
          RD_N <= !dec_rd;
          WR_N <= !dec_wr;
          // write data lands in the same cycle the write strobe falls
          // odd split word on 16-bit bus: low byte rides the upper lane first
          if (second)
            AD_OUT <= {8'h00, wdata[15:8]};
          else if (split && !BYTE_BUS)
            AD_OUT <= {wdata[7:0], 8'h00};
          else
            AD_OUT <= wdata;
          if (kind == 3'h3) begin
            {CYCLE_STATUS_HI, CYCLE_STATUS_MID, CYCLE_STATUS_LO} <=
              `LBC_ST_PASSIVE;
            state <= ST_T4;
          end else begin
            state <= ST_T3;
          end
        end
        ST_T3: begin
          // stay in wait phases while ready sampled low
          if (READY) begin
            {CYCLE_STATUS_HI, CYCLE_STATUS_MID, CYCLE_STATUS_LO} <=
              `LBC_ST_PASSIVE;
            state <= ST_T4;
          end
        end
        ST_T4: begin
          WR_N <= 1'b1;
          // read strobe rises together with write strobe as T4 ends
          RD_N <= 1'b1;
          AD_OE <= 1'b0;
          CS_MEM_N <= 1'b1;
          CS_IO_N <= 1'b1;
          // peripheral word already captured; outside byte is a mirror
          if (dec_rd && !periph) begin
            if (second)
              RDATA[15:8] <= AD_IN[7:0];
            else if (split && !BYTE_BUS)
              RDATA[7:0] <= AD_IN[15:8];
            else if (BYTE_BUS)
              RDATA[7:0] <= AD_IN[7:0];
            else
              RDATA <= AD_IN;
          end
          if (split && !second) begin
            second <= 1'b1;
            addr <= addr + 20'h00001;
            state <= ST_PRE;
          end else begin
            DONE <= 1'b1;
            REQ_READY <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // lbc_cycle_ctrl
`default_nettype wire

/* File: tb/lbc_checker.sv */
// assertions on the local bus cycle controller
`timescale 1ns/1ns
`default_nettype none
module lbc_checker (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // watched
  input wire logic REQ_READY,
  input wire logic READY,
  input wire logic AD_OE,
  input wire logic RD_N,
  input wire logic WR_N,
  input wire logic CYCLE_STATUS_HI,
  input wire logic CYCLE_STATUS_MID,
  input wire logic CYCLE_STATUS_LO,
  input wire logic CS_MEM_N,
  input wire logic CS_IO_N
);
  logic [2:0] st;
  assign st = {CYCLE_STATUS_HI, CYCLE_STATUS_MID, CYCLE_STATUS_LO};
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  a_rd_bus_free: assert property ($fell(RD_N) |-> !AD_OE)
    else $error("rd with bus driven");
  a_rd_code: assert property ($fell(RD_N) |-> st < 3'h2 || st > 3'h3)
    else $error("rd code");
  a_wr_code: assert property ($fell(WR_N) |-> st == 3'h2 || st == 3'h6)
    else $error("wr code");
  a_wr_data: assert property (!WR_N |-> AD_OE)
    else $error("wr data");
  a_end_passive: assert property ($rose(RD_N) |-> $past(st) == 3'h7)
    else $error("status late");
  a_halt_early: assert property (st == 3'h3 [*2] |=> st == 3'h7)
    else $error("halt status");
  a_idle_quiet: assert property (REQ_READY |-> RD_N && WR_N && st == 3'h7)
    else $error("idle busy");
  a_wait_ready: assert property (!RD_N && !READY && st != 3'h7 |=> !RD_N)
    else $error("wait dropped");
  a_cs_space: assert property (!CS_MEM_N |-> CS_IO_N)
    else $error("both chip selects");
  c_rd: cover property ($rose(RD_N));
  c_wr: cover property ($rose(WR_N));
  c_halt: cover property (st == 3'h3);
endmodule // lbc_checker
bind lbc_cycle_ctrl lbc_checker i_lbc_checker (.CLK_SYS(CLK_SYS),
  .RESET(RESET), .REQ_READY(REQ_READY), .READY(READY), .AD_OE(AD_OE),
  .RD_N(RD_N), .WR_N(WR_N), .CYCLE_STATUS_HI(CYCLE_STATUS_HI),
  .CYCLE_STATUS_MID(CYCLE_STATUS_MID), .CYCLE_STATUS_LO(CYCLE_STATUS_LO),
  .CS_MEM_N(CS_MEM_N), .CS_IO_N(CS_IO_N));
`default_nettype wire

/* File: tb/lbc_bus_model.sv */
// byte-wide memory with random wait states on the local bus
`timescale 1ns/1ns
`default_nettype none
module lbc_bus_model (
  input wire logic CLK_SYS,
  input wire logic BYTE_BUS,
  input wire logic [19:0] ADDR,
  input wire logic UPPER_LANE_ENABLE_N,
  input wire logic RD_N,
  input wire logic WR_N,
  input wire logic [15:0] AD_OUT,
  output var logic [15:0] AD_IN,
  output var logic READY
);
  logic [7:0] m [0:255];
  logic [7:0] a;
  integer seed = 32'h57f7;
  assign a = ADDR[7:0];
  initial READY = 1;
  initial AD_IN = 0;
  always @(posedge CLK_SYS) begin
    READY <= ($random(seed) & 3) != 0;
    // data taken only once strobe low a phase
    if (!WR_N && (BYTE_BUS || !a[0]))
      m[a] <= AD_OUT[7:0];
    if (!WR_N && !BYTE_BUS && !UPPER_LANE_ENABLE_N)
      m[a | 8'h01] <= AD_OUT[15:8];
    // released bus toggles so stale data never looks valid
    if (RD_N)
      AD_IN <= ~AD_IN;
    else
      AD_IN <= BYTE_BUS ? {~m[a], m[a]} : {m[a | 8'h01], m[a & 8'hfe]};
  end
endmodule // lbc_bus_model
`default_nettype wire

/* File: tb/tb_lbc_cycle_ctrl.sv */
// self-checking bench for the local bus cycle controller
`timescale 1ns/1ns
`default_nettype none
`define CK(n, e, s) begin n_checks++; if ((s) !== (e)) begin fails++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module tb_lbc_cycle_ctrl;
  logic CLK_SYS = 0, RESET = 1, BYTE_BUS = 0, REQ_VALID = 0, REQ_IO = 0;
  logic REQ_DIRECT = 0, REQ_WORD = 1, REQ_PERIPH = 0, REQ_READY, DONE;
  logic [2:0] REQ_KIND = 0;
  logic [7:0] REQ_PORT8 = 0, a;
  logic [19:0] REQ_ADDR = 0, ADDR;
  logic [15:0] REQ_WDATA = 0, PERIPH_RDATA = 0, RDATA, AD_IN, AD_OUT, d;
  logic [15:0] PERIPH_ADDR;
  logic PERIPH_STB, AD_OE, RD_N, WR_N, READY, UPPER_LANE_ENABLE_N;
  logic [16:0] q [$];
  logic [16:0] e;
  integer fails = 0, n_checks = 0, seed = 32'h57f7, i, bb;
  lbc_cycle_ctrl i_lbc_cycle_ctrl (.CLK_SYS(CLK_SYS), .RESET(RESET),
    .BYTE_BUS(BYTE_BUS), .REQ_VALID(REQ_VALID), .REQ_KIND(REQ_KIND),
    .REQ_IO(REQ_IO), .REQ_DIRECT(REQ_DIRECT), .REQ_PORT8(REQ_PORT8),
    .REQ_ADDR(REQ_ADDR), .REQ_WORD(REQ_WORD), .REQ_PERIPH(REQ_PERIPH),
    .REQ_WDATA(REQ_WDATA), .REQ_READY(REQ_READY), .DONE(DONE),
    .RDATA(RDATA), .PERIPH_STB(PERIPH_STB), .PERIPH_WR(),
    .PERIPH_ADDR(PERIPH_ADDR), .PERIPH_WDATA(),
    .PERIPH_RDATA(PERIPH_RDATA), .READY(READY), .AD_IN(AD_IN),
    .AD_OUT(AD_OUT), .AD_OE(AD_OE), .ADDR(ADDR),
    .UPPER_LANE_ENABLE_N(UPPER_LANE_ENABLE_N), .RD_N(RD_N), .WR_N(WR_N),
    .CYCLE_STATUS_HI(), .CYCLE_STATUS_MID(), .CYCLE_STATUS_LO(),
    .CS_MEM_N(), .CS_IO_N());
  lbc_bus_model i_lbc_bus_model (.CLK_SYS(CLK_SYS), .BYTE_BUS(BYTE_BUS),
    .ADDR(ADDR), .UPPER_LANE_ENABLE_N(UPPER_LANE_ENABLE_N), .RD_N(RD_N),
    .WR_N(WR_N), .AD_OUT(AD_OUT), .AD_IN(AD_IN), .READY(READY));
  always #4 CLK_SYS = ~CLK_SYS;
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // entered just after an edge; returns once DONE shows
  task op(input [2:0] k, input io, dr, pr, input [15:0] wd, input c);
    integer n;
    begin
      {REQ_KIND, REQ_IO, REQ_DIRECT, REQ_PERIPH} = {k, io, dr, pr};
      {REQ_ADDR, REQ_PORT8, REQ_WDATA, REQ_VALID} = {12'h0, a, a, wd, 1'b1};
      for (n = 0; REQ_READY !== 1'b1 && n < 50; n++)
        @(posedge CLK_SYS) #1;
      q.push_back({c, wd});
      @(posedge CLK_SYS) #1;
      REQ_VALID = 0;
      for (n = 0; DONE !== 1'b1 && n < 300; n++)
        @(posedge CLK_SYS) #1;
      if (n >= 300)
        fails++;
    end
  endtask
  always @(posedge CLK_SYS) begin
    if (DONE === 1'b1) begin
      e = q.pop_front();
      if (e[16])
        `CK("rdata", e[15:0], RDATA)
    end
    if (PERIPH_STB === 1'b1)
      `CK("periph_a0", 1'b0, PERIPH_ADDR[0])
  end
  initial begin
    #100000;
    fails++;
    complete_run;
  end
  initial begin
    PERIPH_RDATA = $random(seed);
    repeat (20) @(posedge CLK_SYS);
    #1 RESET = 0;
    for (bb = 0; bb < 2; bb++) begin
      for (i = 0; i < 8; i++) begin
        a = $random(seed);
        d = $random(seed);
        op(3'h2, i[0], 0, 0, d, 0);
        op(3'h1, i[0], 0, 0, d, 1);
      end
      a[0] = 0;
      d = $random(seed);
      op(3'h2, 1, 1, 0, d, 0);
      op(3'h1, 1, 0, 0, d, 1);
      op(3'h4, 0, 0, 0, d, 1);
      op(3'h0, 0, 0, 0, d, 0);
      op(3'h3, 0, 0, 0, d, 0);
      op(3'h1, 0, 0, 1, PERIPH_RDATA, 1);
      // let the last result be compared before reset clears it
      @(posedge CLK_SYS) #1;
      {RESET, BYTE_BUS} = 2'h3;
      repeat (3) @(posedge CLK_SYS);
      #1 RESET = 0;
    end
    @(posedge CLK_SYS) #1;
    if (q.size() != 0)
      fails++;
    complete_run;
  end
endmodule // tb_lbc_cycle_ctrl
`default_nettype wire
